// >>> logic/usb_token_frame_bdt_defs.vh
`ifndef USB_TOKEN_FRAME_BDT_DEFS_VH
`define USB_TOKEN_FRAME_BDT_DEFS_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define ADDR_W 8
`define DATA_W 32
`define OFS_FRAME_HIGH 8'h00
`define OFS_TOKEN 8'h04
`define OFS_PAGE_TWO 8'h08
`define OFS_PAGE_THREE 8'h0C
`define OFS_STATUS 8'h10

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define FRAME_NUM_W 11
`define FRAME_HI_LSB 8
`define FRAME_HI_MSB 10
`define FRAME_HI_RESET 3'h0
`define TOKEN_RESET 8'h00
`define PAGE_RESET 8'h00
`define LOW_PAGE_W 7
`define ALIGN_BITS 9
`define ENTRY_BITS 3
`define BYTE_MSB 7
`define FRAME_FIELD_MSB 2
`define TOK_TYPE_MSB 7
`define TOK_TYPE_LSB 4
`define TOK_EP_MSB 3
`define TOK_EP_LSB 0
`define ST_BUSY 0
`define ST_REJECT 1
`define ST_OVERRUN 2

// ----------------------------------------
// token type codes
// ----------------------------------------
`define TOK_SETUP 4'hD
`define TOK_IN 4'h9
`define TOK_OUT 4'h1

`endif

// >>> logic/token_issuer.v
`timescale 1ns/1ps
`default_nettype none
`include "usb_token_frame_bdt_defs.vh"

module token_issuer (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // software side
  input wire load,
  input wire [7:0] load_value,
  input wire reject_clr,
  input wire overrun_clr,
  // transfer engine side
  input wire token_done,
  output reg token_go,
  // state
  output reg [7:0] token_value,
  output reg busy,
  output reg reject,
  output reg overrun
);

  function is_defined_code;
    input [3:0] code;
    begin
      is_defined_code = (code == `TOK_SETUP) || (code == `TOK_IN) || (code == `TOK_OUT);
    end
  endfunction

  wire accept = load && !busy;
  wire good = is_defined_code(load_value[`TOK_TYPE_MSB:`TOK_TYPE_LSB]);

  // ----------------------------------------
  // token byte and launch
  // ----------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      token_value <= `TOKEN_RESET;
      token_go <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (accept) begin
        token_value <= load_value;
      end
      token_go <= accept && good;
      if (accept && good) begin
        busy <= 1'b1;
      end else if (token_done) begin
        busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // sticky error flags, set wins over clear
  // ----------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reject <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (accept && !good) begin
        reject <= 1'b1;
      end else if (reject_clr) begin
        reject <= 1'b0;
      end
      if (load && busy) begin
        overrun <= 1'b1;
      end else if (overrun_clr) begin
        overrun <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> logic/descriptor_address.v
`timescale 1ns/1ps
`default_nettype none
`include "usb_token_frame_bdt_defs.vh"

module descriptor_address (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // base pages
  input wire [7:0] page_three,
  input wire [7:0] page_two,
  input wire [`LOW_PAGE_W-1:0] low_page,
  // request
  input wire desc_req,
  input wire [3:0] desc_endpoint,
  input wire desc_dir,
  input wire desc_odd,
  // answer
  output wire [31:0] table_base,
  output reg [31:0] desc_addr,
  output reg desc_addr_valid
);

  assign table_base = {page_three, page_two, low_page, {`ALIGN_BITS{1'b0}}};

  // entry offset added to aligned base
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      desc_addr <= 32'h00000000;
      desc_addr_valid <= 1'b0;
    end else begin
      desc_addr_valid <= desc_req;
      if (desc_req) begin
        desc_addr <= {page_three, page_two, low_page,
                      desc_endpoint, desc_dir, desc_odd, {`ENTRY_BITS{1'b0}}};
      end
    end
  end

endmodule
`default_nettype wire

// >>> logic/usb_token_frame_bdt_regs.v
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "usb_token_frame_bdt_defs.vh"

module usb_token_frame_bdt_regs (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`DATA_W-1:0] reg_rdata,
  // start-of-frame from the serial engine
  input wire sof_token,
  input wire [`FRAME_NUM_W-1:0] sof_frame_number,
  // token launch to the transfer engine
  output wire token_go,
  output wire [3:0] token_type_code,
  output wire [3:0] token_endpoint_number,
  input wire token_done,
  // descriptor fetch
  input wire [`LOW_PAGE_W-1:0] table_base_bits_15_9,
  input wire desc_req,
  input wire [3:0] desc_endpoint,
  input wire desc_dir,
  input wire desc_odd,
  output wire [31:0] table_base,
  output wire [31:0] desc_addr,
  output wire desc_addr_valid
);

  reg [2:0] frame_count_upper_bits;
  reg [7:0] table_base_bits_23_16;
  reg [7:0] table_base_bits_31_24;
  reg [`DATA_W-1:0] next_rdata;
  wire [7:0] token_value;
  wire busy;
  wire reject;
  wire overrun;

  wire wr_token = reg_wr && (reg_addr == `OFS_TOKEN);
  wire wr_status = reg_wr && (reg_addr == `OFS_STATUS);

  // ----------------------------------------
  // frame number high
  // ----------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_count_upper_bits <= `FRAME_HI_RESET;
    end else if (sof_token) begin
      frame_count_upper_bits <= sof_frame_number[`FRAME_HI_MSB:`FRAME_HI_LSB];
    end
  end

  // ----------------------------------------
  // descriptor table pages
  // ----------------------------------------
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      table_base_bits_23_16 <= `PAGE_RESET;
      table_base_bits_31_24 <= `PAGE_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `OFS_PAGE_TWO) begin
        table_base_bits_23_16 <= reg_wdata[`BYTE_MSB:0];
      end
      if (reg_addr == `OFS_PAGE_THREE) begin
        table_base_bits_31_24 <= reg_wdata[`BYTE_MSB:0];
      end
    end
  end

  // ----------------------------------------
  // token command
  // ----------------------------------------
  token_issuer i_token_issuer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .load(wr_token),
    .load_value(reg_wdata[`BYTE_MSB:0]),
    .reject_clr(wr_status && reg_wdata[`ST_REJECT]),
    .overrun_clr(wr_status && reg_wdata[`ST_OVERRUN]),
    .token_done(token_done),
    .token_go(token_go),
    .token_value(token_value),
    .busy(busy),
    .reject(reject),
    .overrun(overrun)
  );

  assign token_endpoint_number = token_value[`TOK_EP_MSB:`TOK_EP_LSB];
  assign token_type_code = token_value[`TOK_TYPE_MSB:`TOK_TYPE_LSB];

  // ----------------------------------------
  // descriptor address
  // ----------------------------------------
  descriptor_address i_descriptor_address (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .page_three(table_base_bits_31_24),
    .page_two(table_base_bits_23_16),
    .low_page(table_base_bits_15_9),
    .desc_req(desc_req),
    .desc_endpoint(desc_endpoint),
    .desc_dir(desc_dir),
    .desc_odd(desc_odd),
    .table_base(table_base),
    .desc_addr(desc_addr),
    .desc_addr_valid(desc_addr_valid)
  );

  // ----------------------------------------
  // read mux, data one cycle after strobe
  // ----------------------------------------
  always @* begin
    next_rdata = {`DATA_W{1'b0}};
    if (reg_rd) begin
      case (reg_addr)
        `OFS_FRAME_HIGH: next_rdata[`FRAME_FIELD_MSB:0] = frame_count_upper_bits;
        `OFS_TOKEN: next_rdata[`BYTE_MSB:0] = token_value;
        `OFS_PAGE_TWO: next_rdata[`BYTE_MSB:0] = table_base_bits_23_16;
        `OFS_PAGE_THREE: next_rdata[`BYTE_MSB:0] = table_base_bits_31_24;
        `OFS_STATUS: begin
          next_rdata[`ST_BUSY] = busy;
          next_rdata[`ST_REJECT] = reject;
          next_rdata[`ST_OVERRUN] = overrun;
        end
        default: next_rdata = {`DATA_W{1'b0}};
      endcase
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= {`DATA_W{1'b0}};
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// >>> tb/usb_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_token_frame_bdt_defs.vh"
module usb_regs_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`DATA_W-1:0] reg_rdata,
  // frame, token and descriptor
  input wire logic sof_token,
  input wire logic [`FRAME_NUM_W-1:0] sof_frame_number,
  input wire logic token_go,
  input wire logic [3:0] token_type_code,
  input wire logic [`LOW_PAGE_W-1:0] table_base_bits_15_9,
  input wire logic desc_req,
  input wire logic [3:0] desc_endpoint,
  input wire logic desc_dir,
  input wire logic desc_odd,
  input wire logic [31:0] table_base,
  input wire logic [31:0] desc_addr,
  input wire logic desc_addr_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_frame_capture: assert property ($past(sof_token) && reg_rd && reg_addr == `OFS_FRAME_HIGH
    |=> reg_rdata[2:0] == $past(sof_frame_number[10:8], 2)) else $error("frame bits wrong");
  a_frame_upper_zero: assert property (reg_rd && reg_addr == `OFS_FRAME_HIGH
    |=> reg_rdata[31:3] == 29'h0) else $error("frame upper bits set");
  a_token_valid_code: assert property (token_go
    |-> token_type_code inside {`TOK_SETUP, `TOK_IN, `TOK_OUT}) else $error("bad launch code");
  a_token_upper_zero: assert property (reg_rd && reg_addr == `OFS_TOKEN
    |=> reg_rdata[31:8] == 24'h0) else $error("token upper bits set");
  a_page_two_base: assert property (reg_wr && reg_addr == `OFS_PAGE_TWO
    |=> table_base[23:16] == $past(reg_wdata[7:0])) else $error("page two not in base");
  a_base_low_bits: assert property (
    table_base[15:0] == {table_base_bits_15_9, 9'h000}) else $error("base not aligned");
  a_page_three_base: assert property (reg_wr && reg_addr == `OFS_PAGE_THREE
    |=> table_base[31:24] == $past(reg_wdata[7:0])) else $error("page three not in base");
  a_desc_address: assert property (desc_req |=> desc_addr_valid && desc_addr ==
    {$past(table_base[31:9]), $past(desc_endpoint), $past(desc_dir), $past(desc_odd), 3'h0})
    else $error("descriptor address wrong");
  c_token_launch: cover property (token_go);
  c_desc_answer: cover property (desc_addr_valid);
  c_frame_read: cover property (sof_token ##1 reg_rd);
endmodule
`default_nettype wire

// >>> tb/usb_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// transfer engine stand-in
// ----------------------------------------
module usb_engine_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // token handshake
  input wire logic token_go,
  input wire logic [3:0] lag,
  output logic token_done
);
  logic [3:0] cnt;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 4'h0;
      token_done <= 1'h0;
    end else begin
      token_done <= (cnt == 4'h1);
      if (token_go) cnt <= lag;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_token_frame_bdt_defs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, sof_token = 0, desc_req = 0;
  logic desc_dir = 0, desc_odd = 0, token_go, token_done, desc_addr_valid;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, table_base, desc_addr;
  logic [10:0] sof_frame_number = 11'h000;
  logic [6:0] table_base_bits_15_9 = 7'h55;
  logic [3:0] desc_endpoint = 4'h0, token_type_code, token_endpoint_number, lag = 4'h1;
  logic [3:0] codes [3] = '{4'hD, 4'h9, 4'h1};
  int n_fail = 0, n_checks = 0, n_go = 0;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (token_go === 1'h1) n_go++;
  usb_token_frame_bdt_regs i_usb_token_frame_bdt_regs (.ref_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sof_token, .sof_frame_number, .token_go,
    .token_type_code, .token_endpoint_number, .token_done, .table_base_bits_15_9, .desc_req,
    .desc_endpoint, .desc_dir, .desc_odd, .table_base, .desc_addr, .desc_addr_valid);
  usb_engine_model i_usb_engine_model (.ref_clk, .sys_rst, .token_go, .lag, .token_done);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_rd <= 1'h1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    @(negedge ref_clk);
    `CHK(reg_rdata, e)
    @(posedge ref_clk);
  endtask
  task automatic desc(input logic [3:0] ep, input logic dir, input logic odd,
    input logic [6:0] lp, input logic [31:0] e);
    desc_req <= 1'h1; desc_endpoint <= ep; desc_dir <= dir; desc_odd <= odd;
    table_base_bits_15_9 <= lp;
    @(posedge ref_clk);
    desc_req <= 1'h0;
    @(negedge ref_clk);
    `CHK(desc_addr, e)
    `CHK(desc_addr_valid, 1'h1)
    @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK(desc_addr_valid, 1'h0)
    @(posedge ref_clk);
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    while (token_done !== 1'h1 && k < 20) begin @(negedge ref_clk); k++; end
    `CHK(token_done, 1'h1)
    @(posedge ref_clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    @(posedge ref_clk);
    for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
    $display("test reset_values done");
    wr(`OFS_PAGE_TWO, 32'hFFFF_FFA5);
    wr(`OFS_PAGE_THREE, 32'h1234_563C);
    rd(`OFS_PAGE_TWO, 32'h0000_00A5);
    rd(`OFS_PAGE_THREE, 32'h0000_003C);
    `CHK(table_base, {16'h3CA5, 7'h55, 9'h000})
    desc(4'hF, 1'h1, 1'h0, 7'h55, {16'h3CA5, 7'h55, 4'hF, 2'h2, 3'h0});
    desc(4'h6, 1'h0, 1'h1, 7'h2A, {16'h3CA5, 7'h2A, 4'h6, 2'h1, 3'h0});
    `CHK(table_base, {16'h3CA5, 7'h2A, 9'h000})
    $display("test descriptor_pages done");
    sof_token <= 1'h1; sof_frame_number <= 11'h5AB;
    @(posedge ref_clk);
    sof_token <= 1'h0; sof_frame_number <= 11'h2FF;
    rd(`OFS_FRAME_HIGH, 32'h5);
    wr(`OFS_FRAME_HIGH, 32'hFFFF_FFFF);
    rd(`OFS_FRAME_HIGH, 32'h5);
    sof_token <= 1'h1;
    @(posedge ref_clk);
    sof_token <= 1'h0;
    rd(`OFS_FRAME_HIGH, 32'h2);
    $display("test frame_high done");
    for (int i = 0; i < 3; i++) begin
      lag <= 4'(1 + i * 5);
      wr(`OFS_TOKEN, {24'hFFFFFF, codes[i], 4'(i + 3)});
      `CHK(token_type_code, codes[i])
      `CHK(token_endpoint_number, 4'(i + 3))
      wait_done;
    end
    `CHK(n_go, 3)
    rd(`OFS_TOKEN, 32'h15);
    wr(`OFS_TOKEN, 32'h72);
    rd(`OFS_TOKEN, 32'h72);
    rd(`OFS_STATUS, 32'h2);
    `CHK(n_go, 3)
    wr(`OFS_STATUS, 32'h2);
    rd(`OFS_STATUS, 32'h0);
    lag <= 4'hF;
    wr(`OFS_TOKEN, 32'h94);
    wr(`OFS_TOKEN, 32'hD7);
    rd(`OFS_TOKEN, 32'h94);
    rd(`OFS_STATUS, 32'h5);
    wait_done;
    wr(`OFS_STATUS, 32'h4);
    rd(`OFS_STATUS, 32'h0);
    `CHK(n_go, 4)
    $display("test tokens done");
    conclude;
  end
endmodule
bind usb_token_frame_bdt_regs usb_regs_properties i_usb_regs_properties (.ref_clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sof_token, .sof_frame_number,
  .token_go, .token_type_code, .table_base_bits_15_9, .desc_req, .desc_endpoint, .desc_dir,
  .desc_odd, .table_base, .desc_addr, .desc_addr_valid);
`default_nettype wire
